// *** design/mmd_pkg.sv ***
// Constants and carrier types for the memory map region decoder
package mmd_pkg;
  localparam logic [31:0] FLASH_LO = 32'h0000_0000;
  localparam logic [31:0] FLASH_HI = 32'h0000_FFFF;
  localparam logic [31:0] SRAM_LO = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI = 32'h2000_1FFF;
  localparam logic [31:0] SBAND_HI = 32'h200F_FFFF;
  localparam logic [31:0] SALIAS_LO = 32'h2200_0000;
  localparam logic [31:0] SALIAS_HI = 32'h2203_FFFF;
  localparam logic [31:0] PER_LO = 32'h4000_0000;
  localparam logic [31:0] PER_HI = 32'h400F_FFFF;
  localparam logic [31:0] PALIAS_LO = 32'h4200_0000;
  localparam logic [31:0] PALIAS_HI = 32'h43FF_FFFF;
  localparam logic [31:0] PPB_LO = 32'hE000_0000;
  localparam logic [31:0] PPB_HI = 32'hE00F_FFFF;
  localparam logic [31:0] ITM_BASE = 32'hE000_0000;
  localparam logic [31:0] DWT_BASE = 32'hE000_1000;
  localparam logic [31:0] FPB_BASE = 32'hE000_2000;
  localparam logic [31:0] SCS_BASE = 32'hE000_E000;
  localparam logic [31:0] TPU_BASE = 32'hE004_0000;
  localparam int SLOT_BITS = 12;
  localparam int ALIAS_SHIFT = 5;
  localparam int BIT_SHIFT = 2;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // Target selects, one-hot
  localparam int TGT_W = 9;
  localparam int T_FLASH = 0;
  localparam int T_SRAM = 1;
  localparam int T_PERIPH = 2;
  localparam int T_ITM = 3;
  localparam int T_DWT = 4;
  localparam int T_FPB = 5;
  localparam int T_SCS = 6;
  localparam int T_TPU = 7;
  localparam int T_FAULT = 8;

  typedef enum logic [1:0] {
    MT_NORMAL = 2'b00,
    MT_DEVICE = 2'b01,
    MT_STRONG = 2'b10
  } mmd_mtype_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } mmd_size_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic execute;
    mmd_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mmd_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    mmd_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [TGT_W-1:0] sel;
    mmd_mtype_t mtype;
    logic xn;
    logic buffered;
  } mmd_tgt_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic xn_fault;
    logic [31:0] rdata;
  } mmd_rsp_t;
endpackage

// *** design/mmd_decode.sv ***
// Combinational address decoder: target select, memory type, alias remap
`timescale 1ns/1ps
module mmd_decode import mmd_pkg::*; (
  input wire logic [31:0] addr_i,
  output logic [TGT_W-1:0] sel_o,
  output mmd_mtype_t mtype_o,
  output logic xn_o,
  output logic alias_o,
  output logic [31:0] word_addr_o,
  output logic [2:0] bit_o
);
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_slot(input logic [31:0] a,
                                   input logic [31:0] b);
    in_slot = (a[31:SLOT_BITS] == b[31:SLOT_BITS]);
  endfunction

  logic [31:0] boff;
  logic [31:0] eff;

  always_comb begin
    alias_o = 1'b0;
    boff = ZERO32;
    bit_o = 3'd0;
    eff = addr_i;
    if (in_rng(addr_i, SALIAS_LO, SALIAS_HI)) begin
      alias_o = 1'b1;
      boff = (addr_i - SALIAS_LO) >> ALIAS_SHIFT;
      bit_o = addr_i[4:2];
      eff = SRAM_LO + boff;
    end else if (in_rng(addr_i, PALIAS_LO, PALIAS_HI)) begin
      alias_o = 1'b1;
      boff = (addr_i - PALIAS_LO) >> ALIAS_SHIFT;
      bit_o = addr_i[4:2];
      eff = PER_LO + boff;
    end
    word_addr_o = {eff[31:2], 2'b00};
    sel_o = '0;
    mtype_o = MT_NORMAL;
    xn_o = 1'b0;
    // Full 32-bit region compares, PPB slots compare bits 31:12: one flat fixed map, no relocation
    if (in_rng(eff, FLASH_LO, FLASH_HI)) begin
      sel_o[T_FLASH] = 1'b1;
    end else if (in_rng(eff, SRAM_LO, SRAM_HI)) begin
      sel_o[T_SRAM] = 1'b1;
    end else if (in_rng(eff, PER_LO, PER_HI)) begin
      // Unpopulated slots are forwarded; the peripheral fabric faults them
      sel_o[T_PERIPH] = 1'b1;
      mtype_o = MT_DEVICE;
      xn_o = 1'b1;
    end else if (in_rng(eff, PPB_LO, PPB_HI)) begin
      mtype_o = MT_STRONG;
      xn_o = 1'b1;
      if (in_slot(eff, ITM_BASE)) sel_o[T_ITM] = 1'b1;
      else if (in_slot(eff, DWT_BASE)) sel_o[T_DWT] = 1'b1;
      else if (in_slot(eff, FPB_BASE)) sel_o[T_FPB] = 1'b1;
      else if (in_slot(eff, SCS_BASE)) sel_o[T_SCS] = 1'b1;
      else if (in_slot(eff, TPU_BASE)) sel_o[T_TPU] = 1'b1;
      else sel_o[T_FAULT] = 1'b1;
    end else begin
      sel_o[T_FAULT] = 1'b1;
      xn_o = 1'b1;
    end
  end
endmodule

// *** design/mmd_top.sv ***
// Memory map router: decode, ordering, write posting, bit-band RMW
`timescale 1ns/1ps
module mmd_top import mmd_pkg::*; (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire mmd_req_t req_i,
  output logic req_ready_o,
  output mmd_rsp_t rsp_o,
  output mmd_tgt_t tgt_o,
  input wire logic tgt_ack_i,
  input wire logic tgt_err_i,
  input wire logic [31:0] tgt_rdata_i
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_RMW_RD = 3'b010,
    ST_RMW_WR = 3'b011
  } mmd_state_t;

  typedef struct packed {
    mmd_state_t st;
    logic ready;
    mmd_rsp_t rsp;
    mmd_tgt_t tgt;
    logic posted;
    logic alias_en;
    logic [4:0] bidx;
    logic bitv;
  } mmd_st_t;

  mmd_st_t s_q, s_d;

  logic [TGT_W-1:0] sel;
  mmd_mtype_t mtype;
  logic xn;
  logic alias_hit;
  logic [31:0] waddr;
  logic [2:0] bitn;
  logic [1:0] lane;

  mmd_decode u_dec (
    .addr_i(req_i.addr),
    .sel_o(sel),
    .mtype_o(mtype),
    .xn_o(xn),
    .alias_o(alias_hit),
    .word_addr_o(waddr),
    .bit_o(bitn)
  );

  function automatic logic [3:0] lanes(input mmd_size_t sz,
                                       input logic [1:0] a);
    case (sz)
      SZ_BYTE: lanes = 4'b0001 << a;
      SZ_HALF: lanes = a[1] ? 4'b1100 : 4'b0011;
      default: lanes = 4'b1111;
    endcase
  endfunction

  logic take;
  assign take = req_i.valid && s_q.ready;

  // Byte lane of the access; on an alias it is the lane of the bit's byte
  assign lane = alias_hit ? req_i.addr[ALIAS_SHIFT+1:ALIAS_SHIFT]
                          : req_i.addr[1:0];

  always_comb begin
    s_d = s_q;
    s_d.rsp.done = 1'b0;
    s_d.rsp.fault = 1'b0;
    s_d.rsp.xn_fault = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (take) begin
          s_d.ready = 1'b0;
          s_d.tgt.write = req_i.write;
          s_d.tgt.size = req_i.size;
          s_d.tgt.sel = sel;
          s_d.tgt.mtype = mtype;
          s_d.tgt.xn = xn;
          s_d.alias_en = alias_hit && !req_i.fetch;
          s_d.bidx = {lane, bitn};
          s_d.bitv = req_i.wdata[0];
          // Instruction fetches are not remapped through the alias window
          s_d.tgt.addr = (alias_hit && !req_i.fetch) ? waddr : req_i.addr;
          s_d.tgt.wdata = req_i.wdata;
          s_d.tgt.strb = lanes(req_i.size, lane);
          if (sel[T_FAULT] || (alias_hit && req_i.fetch)) begin
            s_d.st = ST_IDLE;
            s_d.ready = 1'b1;
            s_d.rsp.done = 1'b1;
            s_d.rsp.fault = 1'b1;
          end else if (req_i.fetch && xn) begin
            s_d.ready = 1'b1;
            s_d.rsp.done = 1'b1;
            s_d.rsp.fault = req_i.execute;
            s_d.rsp.xn_fault = req_i.execute;
          end else if (alias_hit && !req_i.fetch && req_i.write) begin
            s_d.tgt.valid = 1'b1;
            s_d.tgt.write = 1'b0;
            s_d.st = ST_RMW_RD;
          end else begin
            s_d.tgt.valid = 1'b1;
            s_d.st = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        s_d.tgt.buffered = s_q.tgt.write && s_q.tgt.mtype == MT_DEVICE
                           && !s_q.alias_en;
        if (s_q.tgt.write && s_q.tgt.mtype == MT_DEVICE && !s_q.alias_en
            && !tgt_ack_i) begin
          s_d.posted = 1'b1;
          // Closed until the post retires: the target port holds the post
          s_d.ready = 1'b0;
          s_d.rsp.done = 1'b1;
          s_d.st = ST_IDLE;
          s_d.tgt.valid = 1'b1;
        end else if (tgt_ack_i) begin
          s_d.tgt.valid = 1'b0;
          s_d.tgt.buffered = 1'b0;
          s_d.ready = 1'b1;
          s_d.rsp.done = 1'b1;
          s_d.rsp.fault = tgt_err_i;
          s_d.rsp.rdata = s_q.alias_en
            ? {31'h0, tgt_rdata_i[s_q.bidx]}
            : tgt_rdata_i;
          s_d.st = ST_IDLE;
        end
      end
      ST_RMW_RD: begin
        if (tgt_ack_i) begin
          s_d.tgt.write = 1'b1;
          s_d.tgt.wdata = tgt_rdata_i;
          s_d.tgt.wdata[s_q.bidx] = s_q.bitv;
          s_d.st = tgt_err_i ? ST_ISSUE : ST_RMW_WR;
          s_d.tgt.valid = !tgt_err_i;
          if (tgt_err_i) begin
            s_d.ready = 1'b1;
            s_d.rsp.done = 1'b1;
            s_d.rsp.fault = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_RMW_WR: begin
        if (tgt_ack_i) begin
          s_d.tgt.valid = 1'b0;
          s_d.ready = 1'b1;
          s_d.rsp.done = 1'b1;
          s_d.rsp.fault = tgt_err_i;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // A posted device write completes in the background; an error on it
    // is lost, since the core was already told it was done
    if (s_q.posted && s_q.st != ST_ISSUE && tgt_ack_i) begin
      s_d.posted = 1'b0;
      if (s_q.st == ST_IDLE) begin
        s_d.tgt.valid = 1'b0;
        s_d.tgt.buffered = 1'b0;
      end
    end
    // Only one access in flight while a post is pending
    if (s_q.posted && s_q.st == ST_IDLE) s_d.ready = 1'b0;
    if (s_q.posted && s_q.st == ST_IDLE && tgt_ack_i) s_d.ready = 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready_o = s_q.ready;
  assign rsp_o = s_q.rsp;
  assign tgt_o = s_q.tgt;

  a_fault_gap: assert property (@(posedge mclk_i) disable iff (srst_i)
    take && sel[T_FAULT] |=> rsp_o.done && rsp_o.fault && !tgt_o.valid)
    else $error("reserved address not faulted");
  a_one_sel: assert property (@(posedge mclk_i) disable iff (srst_i)
    tgt_o.valid |-> $onehot(tgt_o.sel) && !tgt_o.sel[T_FAULT])
    else $error("target select not one-hot");
  a_ppb_strong: assert property (@(posedge mclk_i) disable iff (srst_i)
    tgt_o.valid && (tgt_o.addr[31:20] == 12'hE00) |->
      tgt_o.mtype == MT_STRONG && tgt_o.xn)
    else $error("private bus not strongly ordered");
  a_no_buf_so: assert property (@(posedge mclk_i) disable iff (srst_i)
    tgt_o.buffered |-> tgt_o.mtype == MT_DEVICE)
    else $error("strongly ordered write buffered");
  a_xn_block: assert property (@(posedge mclk_i) disable iff (srst_i)
    take && req_i.fetch && xn && !sel[T_FAULT] && !alias_hit
      |=> !tgt_o.valid && rsp_o.done
      && (rsp_o.xn_fault == $past(req_i.execute)))
    else $error("execute-never fetch not blocked");
  a_order_so: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_q.posted |-> !req_ready_o)
    else $error("access taken while post pending");
  a_alias_addr: assert property (@(posedge mclk_i) disable iff (srst_i)
    take && alias_hit && !req_i.fetch && !sel[T_FAULT] && !s_q.posted
      |=> tgt_o.addr[19:2] == $past(req_i.addr[24:7]))
    else $error("alias word address wrong");
  sequence s_rmw_read;
    s_q.st == ST_RMW_RD && tgt_o.valid && !tgt_o.write && tgt_ack_i
      && !tgt_err_i;
  endsequence
  sequence s_rmw_write;
    tgt_o.valid && tgt_o.write && s_q.st == ST_RMW_WR;
  endsequence
  a_rmw_size: assert property (@(posedge mclk_i) disable iff (srst_i)
    take && !sel[T_FAULT] && !(req_i.fetch && xn) && !s_q.posted
      |=> tgt_o.size == $past(req_i.size))
    else $error("alias size altered");
  a_rmw_seq: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_rmw_read |=> s_rmw_write)
    else $error("alias write not read-modify-write");
endmodule

// *** dv/mmd_target_model.sv ***
// Target-side model: word memory, delayed acknowledge, optional error
`timescale 1ns/1ps
module mmd_target_model import mmd_pkg::*; (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire mmd_tgt_t tgt_i,
  input wire logic [7:0] dly_i,
  input wire logic err_en_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_q [16];
  logic [7:0] cnt_q;
  logic [3:0] idx;
  assign idx = tgt_i.addr[5:2];
  // Read data toggles outside the acknowledge so stale values never match
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      cnt_q <= 8'h00;
      rdata_o <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) mem_q[i] <= 32'h0000_0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      cnt_q <= 8'h00;
      rdata_o <= ~rdata_o;
    end else if (tgt_i.valid && cnt_q >= dly_i) begin
      ack_o <= 1'b1;
      err_o <= err_en_i;
      rdata_o <= mem_q[idx];
      for (int b = 0; b < 4; b++) begin
        if (tgt_i.write && tgt_i.strb[b]) begin
          mem_q[idx][8*b +: 8] <= tgt_i.wdata[8*b +: 8];
        end
      end
    end else begin
      cnt_q <= tgt_i.valid ? cnt_q + 8'h01 : 8'h00;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// *** dv/mmd_top_bench.sv ***
// Self-checking bench for the memory map router
`timescale 1ns/1ps
module mmd_top_bench import mmd_pkg::*; ();
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  mmd_req_t req = '0;
  logic ready;
  mmd_rsp_t rsp;
  mmd_tgt_t tgt;
  logic ack;
  logic err;
  logic [31:0] rdata;
  logic [7:0] dly = 8'h01;
  logic err_en = 1'b0;
  int error_cnt = 0;
  int checked = 0;
  mmd_rsp_t r;
  mmd_tgt_t t;
  logic seen;
  int n;

  mmd_top mmd_top_inst (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
    .req_ready_o(ready), .rsp_o(rsp), .tgt_o(tgt), .tgt_ack_i(ack),
    .tgt_err_i(err), .tgt_rdata_i(rdata));
  mmd_target_model mmd_target_model_inst (.mclk_i(mclk_i),
    .srst_i(srst_i), .tgt_i(tgt), .dly_i(dly), .err_en_i(err_en),
    .ack_o(ack), .err_o(err), .rdata_o(rdata));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One access; records first target phase, response and cycles to done
  task automatic acc(input logic w, input logic f, input logic x,
      input mmd_size_t sz, input logic [31:0] a, input logic [31:0] d);
    seen = 1'b0;
    n = 0;
    // One idle edge keeps the last release and this request apart
    @(negedge mclk_i);
    req <= '{1'b1, w, f, x, sz, a, d};
    // Held until ready is seen high at a rising edge
    while (ready !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
    req <= '0;
    for (int k = 0; k < 60; k++) begin
      if (tgt.valid === 1'b1 && !seen) begin
        t = tgt;
        seen = 1'b1;
      end
      if (rsp.done === 1'b1) break;
      n++;
      @(negedge mclk_i);
    end
    r = rsp;
    check(r.done, 1'b1);
  endtask

  task automatic t_reserved();
    logic [31:0] a [7] = '{32'h0001_0000, 32'h2000_2000, 32'h2204_0000,
      32'h4400_0000, 32'hE000_3000, 32'hE004_1000, 32'hE010_0000};
    for (int i = 0; i < 7; i++) begin
      acc(1'(i % 2), 1'b0, 1'b0, SZ_WORD, a[i], 32'h1234_5678);
      check(r.fault, 1'b1);
      check(seen, 1'b0);
    end
    err_en = 1'b1;
    acc(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h4000_1000, 32'h0000_0000);
    check(r.fault, 1'b1);
    err_en = 1'b0;
    $display("test reserved done");
  endtask

  task automatic t_decode();
    logic [31:0] a [10] = '{32'h0000_0004, 32'h2000_1FFC, 32'h4003_0010,
      32'h400F_E000, 32'hE000_0000, 32'hE000_1000, 32'hE000_2000,
      32'hE000_E000, 32'hE000_EFFC, 32'hE004_0FFC};
    int s [10] = '{T_FLASH, T_SRAM, T_PERIPH, T_PERIPH, T_ITM, T_DWT,
      T_FPB, T_SCS, T_SCS, T_TPU};
    logic [31:0] sel;
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 1'b0, 1'b0, SZ_WORD, a[i], 32'h0000_0000);
      sel = 32'h0000_0001 << s[i];
      check(32'(t.sel), sel);
      check(t.addr, a[i]);
      check(r.fault, 1'b0);
      check(32'(t.mtype), i < 2 ? MT_NORMAL : i < 4 ? MT_DEVICE
        : MT_STRONG);
      check(t.xn, i > 1);
    end
    $display("test decode done");
  endtask

  task automatic t_lanes();
    acc(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h2000_0000, 32'h1122_3344);
    check(t.strb, 4'hF);
    acc(1'b1, 1'b0, 1'b0, SZ_HALF, 32'h2000_0002, 32'hAABB_0000);
    check(t.strb, 4'hC);
    check(32'(t.size), SZ_HALF);
    acc(1'b1, 1'b0, 1'b0, SZ_BYTE, 32'h2000_0001, 32'h0000_CC00);
    check(t.strb, 4'h2);
    acc(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h2000_0000, 32'h0000_0000);
    check(r.rdata, 32'hAABB_CC44);
    $display("test lanes done");
  endtask

  task automatic t_alias();
    acc(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h2000_0004, 32'hA5A5_0000);
    acc(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h2200_008C, 32'h0000_0001);
    check(t.addr, 32'h2000_0004);
    check(t.write, 1'b0);
    check(32'(t.size), SZ_WORD);
    acc(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h2000_0004, 32'h0000_0000);
    check(r.rdata, 32'hA5A5_0008);
    acc(1'b1, 1'b0, 1'b0, SZ_BYTE, 32'h2200_00A4, 32'h0000_0001);
    check(t.addr, 32'h2000_0004);
    check(t.strb, 4'h2);
    acc(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h2000_0004, 32'h0000_0000);
    check(r.rdata, 32'hA5A5_0208);
    acc(1'b0, 1'b0, 1'b0, SZ_HALF, 32'h2200_008C, 32'h0000_0000);
    check(r.rdata[0], 1'b1);
    check(32'(t.size), SZ_HALF);
    acc(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h4260_0008, 32'h0000_0000);
    check(t.addr, 32'h4003_0000);
    check(32'(t.sel), 32'h0000_0001 << T_PERIPH);
    $display("test alias done");
  endtask

  task automatic t_xn();
    acc(1'b0, 1'b1, 1'b0, SZ_WORD, 32'h4000_0000, 32'h0000_0000);
    check(seen, 1'b0);
    check(r.xn_fault, 1'b0);
    acc(1'b0, 1'b1, 1'b1, SZ_WORD, 32'hE000_E000, 32'h0000_0000);
    check(seen, 1'b0);
    check(r.xn_fault, 1'b1);
    acc(1'b0, 1'b1, 1'b1, SZ_WORD, 32'h0000_0008, 32'h0000_0000);
    check(seen, 1'b1);
    check(r.xn_fault, 1'b0);
    $display("test execute never done");
  endtask

  // Slow target: posted device write returns early, ordered one waits
  task automatic t_post();
    dly = 8'h05;
    acc(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h4000_4000, 32'h0000_00FF);
    check(tgt.buffered, 1'b1);
    check(ready, 1'b0);
    check(n <= 2, 1'b1);
    acc(1'b1, 1'b0, 1'b0, SZ_WORD, 32'hE000_E010, 32'h0000_0001);
    check(t.buffered, 1'b0);
    check(n > 5, 1'b1);
    dly = 8'h01;
    $display("test posting done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check(ready, 1'b1);
    check(rsp.done, 1'b0);
    check(tgt.valid, 1'b0);
    t_reserved();
    t_decode();
    t_lanes();
    t_alias();
    t_xn();
    t_post();
    test_done();
  end

  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
